//--- design/laser_status_fault_sequencer.sv
`default_nettype none
module laser_status_fault_sequencer #(
  parameter longint unsigned WARMUP_CYCLES = laser_seq_pkg::WARMUP_CYC,
  parameter longint unsigned PAUSE_CYCLES = laser_seq_pkg::PAUSE_CYC,
  parameter longint unsigned OPEN_CYCLES = laser_seq_pkg::OPEN_CYC,
  parameter longint unsigned CLOSE_CYCLES = laser_seq_pkg::CLOSE_CYC,
  parameter longint unsigned BLINK_ON_CYCLES = laser_seq_pkg::BLINK_ON_CYC,
  parameter longint unsigned BLINK_OFF_CYCLES = laser_seq_pkg::BLINK_OFF_CYC,
  parameter longint unsigned TICKLE_PERIOD_CYCLES =
    laser_seq_pkg::TICKLE_PERIOD_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic interlockOk,
  input wire logic shutterOpenRequest,
  input wire logic pulseCommand,
  input wire laser_seq_pkg::faults_t faultIn,
  output laser_seq_pkg::lamps_t lamps,
  output laser_seq_pkg::lamps_t statusOut,
  output logic laserReadyOut,
  output logic faultDetectedOut,
  output logic shutterDrive,
  output logic rfEnable,
  output logic rfDrive
);
  localparam int W = laser_seq_pkg::CNT_W;

  function automatic logic [W-1:0] cyc(input longint unsigned n);
    cyc = (n > 64'd1) ? W'(n - 64'd1) : '0;
  endfunction : cyc

  function automatic logic shut_open(input laser_seq_pkg::shutter_t s);
    shut_open = (s == laser_seq_pkg::SH_OPEN);
  endfunction : shut_open

  // Two-stage synchronisers; only the second stage is used.
  logic [10:0] syncA;
  logic [10:0] syncB;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {interlockOk, shutterOpenRequest, pulseCommand,
        faultIn};
      syncB <= syncA;
    end
  end

  // The synchroniser reads zero until it has seen the pins twice, which
  // would look like an open interlock; this marks when its output is real.
  logic [1:0] primed;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      primed <= '0;
    end else begin
      primed <= {primed[0], 1'b1};
    end
  end

  logic intOk;
  logic shReq;
  logic pwm;
  laser_seq_pkg::faults_t flt;
  assign intOk = syncB[10];
  assign shReq = syncB[9];
  assign pwm = syncB[8];
  assign flt = syncB[7:0];

  // Power-cycle-cleared faults stay latched; only reset clears them.
  laser_seq_pkg::faults_t latched;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latched <= '0;
    end else begin
      latched.overTemp <= latched.overTemp | flt.overTemp;
      latched.underVolt <= latched.underVolt | flt.underVolt;
      latched.overVolt <= latched.overVolt | flt.overVolt;
      latched.rfSwitch <= latched.rfSwitch | flt.rfSwitch;
      latched.pwmDrive <= latched.pwmDrive | flt.pwmDrive;
      latched.preCharge <= latched.preCharge | flt.preCharge;
      // No-strike and frequency limit clear by themselves.
      latched.noStrike <= flt.noStrike;
      latched.freqLimit <= flt.freqLimit;
    end
  end

  // A fault acts in the cycle it arrives as well as once latched, so that
  // readiness never flickers on while a fault is first being captured.
  laser_seq_pkg::faults_t held;
  assign held = latched | flt;

  // Blink code of the highest-priority latched supply or drive fault.
  logic [2:0] code;
  always_comb begin
    code = laser_seq_pkg::CODE_NONE;
    if (held.underVolt) begin
      code = laser_seq_pkg::CODE_UNDERV;
    end else if (held.overVolt) begin
      code = laser_seq_pkg::CODE_OVERV;
    end else if (held.rfSwitch) begin
      code = laser_seq_pkg::CODE_RFSW;
    end else if (held.pwmDrive) begin
      code = laser_seq_pkg::CODE_PWMDRV;
    end else if (held.preCharge) begin
      code = laser_seq_pkg::CODE_PRECHG;
    end
  end

  // A ready-output-opening supply fault; the switch fault keeps it closed.
  logic supplyOpen;
  assign supplyOpen = held.underVolt | held.overVolt |
    held.preCharge | held.pwmDrive;
  logic healthy;
  assign healthy = intOk & ~held.overTemp & ~supplyOpen &
    ~held.rfSwitch;

  // Warm-up counter restarts whenever readiness drops.
  logic [W-1:0] warmCnt;
  logic warmDone;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      warmCnt <= '0;
      warmDone <= 1'b0;
    end else if (!healthy) begin
      warmCnt <= '0;
      warmDone <= 1'b0;
    end else if (!warmDone) begin
      if (warmCnt == cyc(WARMUP_CYCLES)) begin
        warmDone <= 1'b1;
      end else begin
        warmCnt <= warmCnt + 1'b1;
      end
    end
  end

  // Shutter movement timing; open only counts once fully travelled.
  laser_seq_pkg::shutter_t shState;
  logic [W-1:0] shCnt;
  logic shWant;
  assign shWant = shReq & healthy;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shState <= laser_seq_pkg::SH_CLOSED;
      shCnt <= '0;
    end else begin
      unique case (shState)
        laser_seq_pkg::SH_CLOSED: begin
          shCnt <= '0;
          if (shWant) begin
            shState <= laser_seq_pkg::SH_OPENING;
          end
        end
        laser_seq_pkg::SH_OPENING: begin
          shCnt <= shCnt + 1'b1;
          if (!shWant) begin
            shState <= laser_seq_pkg::SH_CLOSING;
            shCnt <= '0;
          end else if (shCnt == cyc(OPEN_CYCLES)) begin
            shState <= laser_seq_pkg::SH_OPEN;
          end
        end
        laser_seq_pkg::SH_OPEN: begin
          shCnt <= '0;
          if (!shWant) begin
            shState <= laser_seq_pkg::SH_CLOSING;
          end
        end
        laser_seq_pkg::SH_CLOSING: begin
          shCnt <= shCnt + 1'b1;
          if (shCnt == cyc(CLOSE_CYCLES)) begin
            shState <= laser_seq_pkg::SH_CLOSED;
            shCnt <= '0;
          end
        end
      endcase
    end
  end

  // Emission needs everything at once; dropping any term stops it now.
  logic next_emit;
  assign next_emit = healthy & warmDone & shWant & pwm &
    shut_open(shState) & ~held.freqLimit;

  // Tickle keeps the discharge warm while ready but not emitting.
  logic [W-1:0] tickCnt;
  logic tickle;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tickCnt <= '0;
    end else if (!healthy || tickCnt == cyc(TICKLE_PERIOD_CYCLES)) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= tickCnt + 1'b1;
    end
  end
  assign tickle = healthy & (tickCnt == '0);

  // Blink sequencer: count flashes, then pause, then repeat.
  laser_seq_pkg::blink_t blState;
  logic [W-1:0] blCnt;
  logic [2:0] blNum;
  logic [W-1:0] stCnt;
  logic strobe;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      blState <= laser_seq_pkg::BL_IDLE;
      blCnt <= '0;
      blNum <= '0;
    end else begin
      unique case (blState)
        laser_seq_pkg::BL_IDLE: begin
          blCnt <= '0;
          blNum <= '0;
          if (code != laser_seq_pkg::CODE_NONE) begin
            blState <= laser_seq_pkg::BL_ON;
          end
        end
        laser_seq_pkg::BL_ON: begin
          blCnt <= blCnt + 1'b1;
          if (blCnt == cyc(BLINK_ON_CYCLES)) begin
            blCnt <= '0;
            blNum <= blNum + 1'b1;
            blState <= laser_seq_pkg::BL_OFF;
          end
        end
        laser_seq_pkg::BL_OFF: begin
          blCnt <= blCnt + 1'b1;
          if (blCnt == cyc(BLINK_OFF_CYCLES)) begin
            blCnt <= '0;
            blState <= (blNum == code) ? laser_seq_pkg::BL_PAUSE
              : laser_seq_pkg::BL_ON;
          end
        end
        laser_seq_pkg::BL_PAUSE: begin
          blCnt <= blCnt + 1'b1;
          if (blCnt == cyc(PAUSE_CYCLES)) begin
            blCnt <= '0;
            blNum <= '0;
            blState <= laser_seq_pkg::BL_ON;
          end
        end
      endcase
    end
  end

  // Free-running strobe for the continuous no-strike flash.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stCnt <= '0;
      strobe <= 1'b0;
    end else if (stCnt == cyc(BLINK_ON_CYCLES)) begin
      stCnt <= '0;
      strobe <= ~strobe;
    end else begin
      stCnt <= stCnt + 1'b1;
    end
  end

  // Lamps and their mirrored outputs, all registered.
  laser_seq_pkg::lamps_t next_lamps;
  always_comb begin
    next_lamps.interlockFault = primed[1] & ~intOk;
    next_lamps.temperatureFault = latched.overTemp;
    next_lamps.readyLamp = intOk & ((code != laser_seq_pkg::CODE_NONE) ?
      (blState == laser_seq_pkg::BL_ON) : healthy);
    next_lamps.shutterLamp = intOk & (latched.noStrike ? strobe :
      (shWant & shut_open(shState)));
    next_lamps.emissionLamp = next_emit;
  end

  // Lamps and their mirrors leave from one flip-flop stage, so the
  // controller never sees the two disagree.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lamps <= '0;
      statusOut <= '0;
    end else begin
      lamps <= next_lamps;
      statusOut <= next_lamps;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      laserReadyOut <= 1'b0;
    end else begin
      laserReadyOut <= healthy | (held.rfSwitch & intOk &
        ~held.overTemp & ~supplyOpen);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      faultDetectedOut <= 1'b0;
    end else begin
      faultDetectedOut <= latched.overTemp | latched.noStrike;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shutterDrive <= 1'b0;
    end else begin
      shutterDrive <= shWant;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rfEnable <= 1'b0;
    end else begin
      rfEnable <= healthy;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rfDrive <= 1'b0;
    end else begin
      rfDrive <= next_emit | tickle;
    end
  end
endmodule : laser_status_fault_sequencer
`default_nettype wire

//--- dv/ctrl_model.sv
`default_nettype none
module ctrl_model (
  input wire logic clock,
  input wire logic wantIlk,
  input wire logic wantShut,
  input wire logic wantPulse,
  output var logic interlockOk = 1'b0,
  output var logic shutterOpenRequest = 1'b0,
  output var logic pulseCommand = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // The machine side moves its lines only just after a clock edge.
  always @(posedge clock) begin
    interlockOk <= wantIlk;
    shutterOpenRequest <= wantShut;
    pulseCommand <= wantPulse;
  end
endmodule : ctrl_model
`default_nettype wire

//--- dv/laser_seq_checker_assertions.sv
`default_nettype none
module laser_seq_checker #(
  parameter longint unsigned WARMUP_CYCLES = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic interlockOk,
  input wire logic shutterOpenRequest,
  input wire laser_seq_pkg::faults_t faultIn,
  input wire laser_seq_pkg::lamps_t lamps,
  input wire laser_seq_pkg::lamps_t statusOut,
  input wire logic laserReadyOut,
  input wire logic faultDetectedOut,
  input wire logic shutterDrive,
  input wire logic rfEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Counts unbroken RF health, since any loss of health restarts warm-up.
  logic [31:0] enCnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) enCnt <= 32'h0000_0000;
    else if (!rfEnable) enCnt <= 32'h0000_0000;
    else if (enCnt != 32'hFFFF_FFFF) enCnt <= enCnt + 32'h0000_0001;
  end
  sequence s_ilk_lost; $fell(interlockOk); endsequence
  sequence s_req_gone; $fell(shutterOpenRequest); endsequence
  sequence s_freq_high; faultIn.freqLimit [*3]; endsequence
  a_status_mirror: assert property (statusOut == lamps)
    else $error("status outputs differ from lamps");
  a_ready_health: assert property (lamps.readyLamp |->
    !lamps.interlockFault && !lamps.temperatureFault)
    else $error("ready lamp lit while unhealthy");
  a_open_ilk_dark: assert property (lamps.interlockFault |->
    !lamps.readyLamp && !lamps.shutterLamp && !rfEnable)
    else $error("shutter, ready or RF active with interlock open");
  a_ilk_loss_stop: assert property (s_ilk_lost |-> ##3
    lamps.interlockFault && !shutterDrive && !lamps.emissionLamp)
    else $error("interlock loss not acted on in three cycles");
  a_emit_needs_shut: assert property (lamps.emissionLamp |->
    lamps.shutterLamp && rfEnable)
    else $error("emission without open shutter");
  a_withdraw_block: assert property (s_req_gone |-> ##3
    !lamps.emissionLamp)
    else $error("emission kept after request withdrawn");
  a_warm_wait: assert property (lamps.emissionLamp |->
    enCnt >= WARMUP_CYCLES - 1)
    else $error("emission before warm-up elapsed");
  a_temp_latched: assert property (lamps.temperatureFault |=>
    lamps.temperatureFault && faultDetectedOut && !lamps.readyLamp)
    else $error("over-temperature state not held");
  a_supply_open: assert property ((faultIn.underVolt ||
    faultIn.overVolt || faultIn.preCharge) |-> ##3 !laserReadyOut)
    else $error("laser ready output closed under supply fault");
  a_freq_block: assert property (s_freq_high |=>
    !lamps.emissionLamp)
    else $error("emission above frequency limit");
endmodule : laser_seq_checker
bind laser_status_fault_sequencer laser_seq_checker #(
  .WARMUP_CYCLES(WARMUP_CYCLES)
) i_laser_seq_checker (.clock(clock), .rst(rst),
  .interlockOk(interlockOk), .shutterOpenRequest(shutterOpenRequest),
  .faultIn(faultIn), .lamps(lamps), .statusOut(statusOut),
  .laserReadyOut(laserReadyOut), .faultDetectedOut(faultDetectedOut),
  .shutterDrive(shutterDrive), .rfEnable(rfEnable));
`default_nettype wire

//--- dv/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BLINK = 6;
  localparam int PAUSE = 16;
  localparam int WARM = 20;
  localparam int SHUT_OPEN = 8;
  localparam int SHUT_CLOSE = 12;
  localparam int BLINK_HALF = 3;
  localparam int TICK = 5;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wIlk = 1'b0;
  logic wShut = 1'b0;
  logic wPulse = 1'b0;
  laser_seq_pkg::faults_t faultIn = 8'h00;
  laser_seq_pkg::lamps_t lamps;
  laser_seq_pkg::lamps_t statusOut;
  wire logic ilk, shutReq, pulse;
  logic rdyOut, fdet, shDrv, rfEn, rfDrv, prev;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 69519;
  int k, n;
  always #4 clock = ~clock;
  ctrl_model i_ctrl_model (.clock(clock), .wantIlk(wIlk),
    .wantShut(wShut), .wantPulse(wPulse), .interlockOk(ilk),
    .shutterOpenRequest(shutReq), .pulseCommand(pulse));
  laser_status_fault_sequencer #(.WARMUP_CYCLES(WARM), .PAUSE_CYCLES(PAUSE),
    .OPEN_CYCLES(SHUT_OPEN), .CLOSE_CYCLES(SHUT_CLOSE),
    .BLINK_ON_CYCLES(BLINK_HALF), .BLINK_OFF_CYCLES(BLINK_HALF),
    .TICKLE_PERIOD_CYCLES(TICK)
  ) i_laser_status_fault_sequencer (.clock(clock), .rst(rst),
    .interlockOk(ilk), .shutterOpenRequest(shutReq),
    .pulseCommand(pulse), .faultIn(faultIn), .lamps(lamps),
    .statusOut(statusOut), .laserReadyOut(rdyOut),
    .faultDetectedOut(fdet), .shutterDrive(shDrv), .rfEnable(rfEn),
    .rfDrive(rfDrv));
  function automatic logic exp_rdy(input int i);
    return i == 2;
  endfunction : exp_rdy
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask : cyc
  task automatic pwr(input laser_seq_pkg::faults_t f);
    @(posedge clock);
    rst <= 1'b1;
    faultIn <= f;
    wIlk <= 1'b1;
    wShut <= 1'b0;
    wPulse <= 1'b0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    #1;
  endtask : pwr
  task automatic wait_emit;
    for (k = 0; k < 100 && lamps.emissionLamp !== 1'b1; k++) cyc(1);
    if (k == 100) begin
      error_cnt++;
      wrap_up();
    end
  endtask : wait_emit
  task automatic tog(input int c);
    n = 0;
    prev = lamps.shutterLamp;
    repeat (c) begin
      cyc(1);
      n += int'(lamps.shutterLamp !== prev);
      prev = lamps.shutterLamp;
    end
  endtask : tog
  initial begin
    #700us;
    error_cnt++;
    wrap_up();
  end
  initial begin
    pwr(8'h00);
    chk({lamps, rdyOut, fdet, shDrv, rfEn, rfDrv}, 16'h0000);
    cyc(4);
    chk({lamps.readyLamp, rfEn, lamps.interlockFault}, 3'b110);
    @(posedge clock);
    wShut <= 1'b1;
    wPulse <= 1'b1;
    n = 0;
    repeat (10) begin
      cyc(1);
      n += int'(rfDrv);
    end
    chk(lamps.emissionLamp, 1'b0);
    chk(n > 0, 1'b1);
    wait_emit();
    chk({lamps.shutterLamp, rfDrv}, 2'b11);
    @(posedge clock);
    wShut <= 1'b0;
    cyc(4);
    chk(lamps.emissionLamp, 1'b0);
    @(posedge clock);
    wIlk <= 1'b0;
    wShut <= 1'b1;
    cyc(12);
    chk({lamps.interlockFault, lamps.readyLamp, lamps.shutterLamp, shDrv,
      rfEn, statusOut.interlockFault}, 6'b100001);
    @(posedge clock);
    wIlk <= 1'b1;
    cyc(4);
    chk(lamps.readyLamp, 1'b1);
    cyc(8);
    chk(lamps.emissionLamp, 1'b0);
    wait_emit();
    // Random traffic leans to an open shutter so emission really occurs.
    repeat (300) begin
      @(posedge clock);
      wShut <= $random(seed) % 8 != 0;
      wPulse <= 1'($random(seed));
      faultIn.freqLimit <= 1'($random(seed));
    end
    for (int i = 0; i < 5; i++) begin
      pwr(8'h80 >> i);
      for (k = 0; k < 100 && lamps.readyLamp !== 1'b1; k++) cyc(1);
      if (k == 100) begin
        error_cnt++;
        wrap_up();
      end
      prev = 1'b1;
      n = 0;
      repeat ((i + 1) * BLINK + PAUSE) begin
        cyc(1);
        n += int'(lamps.readyLamp & ~prev);
        prev = lamps.readyLamp;
      end
      chk(16'(n), 16'(i + 1));
      if (i != 3) chk(rdyOut, exp_rdy(i));
    end
    pwr(8'h00);
    cyc(4);
    @(posedge clock);
    faultIn.overTemp <= 1'b1;
    cyc(4);
    @(posedge clock);
    faultIn.overTemp <= 1'b0;
    cyc(8);
    chk({lamps.temperatureFault, lamps.readyLamp, fdet,
      lamps.emissionLamp}, 4'b1010);
    pwr(8'h02);
    cyc(4);
    tog(12);
    chk(n >= 3, 1'b1);
    chk(fdet, 1'b1);
    @(posedge clock);
    faultIn.noStrike <= 1'b0;
    cyc(6);
    tog(12);
    chk(16'(n), 16'h0000);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire

//--- shared/laser_seq_pkg.sv
`default_nettype none
package laser_seq_pkg;
  localparam int unsigned CLOCK_HZ = 125_000_000;
  // Times in their own units, cycle counts derived from the clock rate.
  localparam int unsigned WARMUP_S = 5;
  localparam int unsigned PAUSE_S = 4;
  localparam int unsigned OPEN_MS = 30;
  localparam int unsigned CLOSE_MS = 120;
  localparam int unsigned BLINK_ON_MS = 250;
  localparam int unsigned BLINK_OFF_MS = 250;
  localparam int unsigned TICKLE_US = 1;
  localparam int unsigned TICKLE_PERIOD_US = 200;
  localparam longint unsigned WARMUP_CYC = longint'(WARMUP_S) * CLOCK_HZ;
  localparam longint unsigned PAUSE_CYC = longint'(PAUSE_S) * CLOCK_HZ;
  localparam longint unsigned OPEN_CYC = longint'(OPEN_MS) * CLOCK_HZ / 1000;
  localparam longint unsigned CLOSE_CYC =
    longint'(CLOSE_MS) * CLOCK_HZ / 1000;
  localparam longint unsigned BLINK_ON_CYC =
    longint'(BLINK_ON_MS) * CLOCK_HZ / 1000;
  localparam longint unsigned BLINK_OFF_CYC =
    longint'(BLINK_OFF_MS) * CLOCK_HZ / 1000;
  localparam longint unsigned TICKLE_CYC =
    longint'(TICKLE_US) * CLOCK_HZ / 1_000_000;
  localparam longint unsigned TICKLE_PERIOD_CYC =
    longint'(TICKLE_PERIOD_US) * CLOCK_HZ / 1_000_000;
  localparam int CNT_W = 32;
  localparam logic [2:0] CODE_UNDERV = 3'h1;
  localparam logic [2:0] CODE_OVERV = 3'h2;
  localparam logic [2:0] CODE_RFSW = 3'h3;
  localparam logic [2:0] CODE_PWMDRV = 3'h4;
  localparam logic [2:0] CODE_PRECHG = 3'h5;
  localparam logic [2:0] CODE_NONE = 3'h0;

  // Fault indications from the sensing circuits, active high.
  typedef struct packed {
    logic underVolt;
    logic overVolt;
    logic rfSwitch;
    logic pwmDrive;
    logic preCharge;
    logic overTemp;
    logic noStrike;
    logic freqLimit;
  } faults_t;

  // Lamp states; each is also mirrored onto a status output.
  typedef struct packed {
    logic interlockFault;
    logic temperatureFault;
    logic readyLamp;
    logic shutterLamp;
    logic emissionLamp;
  } lamps_t;

  typedef enum logic [1:0] {BL_IDLE, BL_ON, BL_OFF, BL_PAUSE} blink_t;
  typedef enum logic [1:0] {SH_CLOSED, SH_OPENING, SH_OPEN, SH_CLOSING}
    shutter_t;
endpackage : laser_seq_pkg
`default_nettype wire
